//--- src/chgseq_defs.svh
// constants for the charger control sequencer
`ifndef CHGSEQ_DEFS_SVH
`define CHGSEQ_DEFS_SVH
`define CHGSEQ_CLK_MHZ      250
`define CHGSEQ_TICK_US      1000
`define CHGSEQ_TICK_CYC     (`CHGSEQ_TICK_US * `CHGSEQ_CLK_MHZ)
`define CHGSEQ_RATIO_FULL   8'hff
`define CHGSEQ_NOM_WEIGHT   3'h2
`define CHGSEQ_A_CTRL       12'h000
`define CHGSEQ_A_TIMER      12'h004
`define CHGSEQ_A_STATUS     12'h008
`define CHGSEQ_CTRL_RST     32'h0000_0006
`define CHGSEQ_TIMER_RST    32'h0000_3c1e
`define CHGSEQ_C_EN         0
`define CHGSEQ_C_TERM       1
`define CHGSEQ_C_SCL        3:2
`define CHGSEQ_C_PRE        5:4
`define CHGSEQ_C_SHIFT      7:6
`define CHGSEQ_T_PRE        7:0
`define CHGSEQ_T_FAST       15:8
`define CHGSEQ_S_ACTIVE     0
`define CHGSEQ_S_FAULT      1
`define CHGSEQ_S_SUSP       2
`define CHGSEQ_S_TREG       3
`define CHGSEQ_S_HOT        4
`define CHGSEQ_S_STATE      11:5
`endif

//--- src/chgseq_pkg.sv
// types shared by the charger control sequencer
package chgseq_pkg;
  typedef enum logic [6:0] {
    CHGSEQ_IDLE  = 7'h01,
    CHGSEQ_SHORT = 7'h02,
    CHGSEQ_PRE   = 7'h04,
    CHGSEQ_FAST  = 7'h08,
    CHGSEQ_CV    = 7'h10,
    CHGSEQ_DONE  = 7'h20,
    CHGSEQ_FAULT = 7'h40
  } chgseq_state_t;
endpackage : chgseq_pkg

//--- src/chgseq_tmr_if.sv
// link between the sequencer and one safety timer
`timescale 1ns/10ps
`default_nettype none
interface chgseq_tmr_if;
  logic        run;     // advance allowed
  logic        clr;     // restart from zero
  logic [10:0] step;    // weight times current ratio, full ratio for precharge
  logic [7:0]  limit;   // expiry in ticks
  logic        expired; // tick count reached limit
  modport ctl (output run, output clr, output step, output limit, input expired);
  modport tmr (input run, input clr, input step, input limit, output expired);
endinterface : chgseq_tmr_if
`default_nettype wire

//--- src/chgseq_timer.sv
// rate-gated safety timer
`timescale 1ns/10ps
`default_nettype none
`include "chgseq_defs.svh"
module chgseq_timer #(
  parameter int TICK_CYC = `CHGSEQ_TICK_CYC
) (
  input wire logic   pclk,
  input wire logic   presetn,
  chgseq_tmr_if.tmr  t
);
  // one tick costs nominal weight times full ratio per cycle
  localparam logic [39:0] THRESH = 40'(TICK_CYC) * 40'(`CHGSEQ_NOM_WEIGHT)
                                   * 40'(`CHGSEQ_RATIO_FULL);
  logic [39:0] acc; // fractional progress
  logic [7:0]  cnt; // whole ticks

  // accumulate; held (not cleared) while run and clr are both low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc <= 40'h00_0000_0000;
      cnt <= 8'h00;
    end else if (t.clr) begin
      acc <= 40'h00_0000_0000;
      cnt <= 8'h00;
    end else if (t.run) begin // [R19]
      if (acc + 40'(t.step) >= THRESH) begin
        acc <= acc + 40'(t.step) - THRESH;
        if (cnt != 8'hff) cnt <= cnt + 8'h01;
      end else begin
        acc <= acc + 40'(t.step);
      end
    end
  end

  // expiry flag from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) t.expired <= 1'b0;
    else t.expired <= !t.clr && (cnt >= t.limit);
  end
endmodule : chgseq_timer
`default_nettype wire

//--- src/chgseq_top.sv
// charger control sequencer with apb registers
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "chgseq_defs.svh"
// Operation
// [R1] termination off: pre, fast, cv, stay cv
// [R2] termination off: no battery detection
// [R3] termination off: flag clears, held until repower
// [R4] termination off disables both safety timers
// [R5] ts sensing off: no termination, open ts
// [R6] scale 01 runs timers at nominal rate
// [R7] timers scale inversely; 11 halves time
// [R8] precharge current leaves timers unchanged
// [R9] fast charge: timers slow with current
// [R10] precharge timeout before exit voltage: fault
// [R11] fast timeout without termination current: fault
// [R12] die above regulation: reduce charge current
// [R13] shutdown: input fet off, battery fet on
// [R14] ts out of window: suspend, freeze timers
// [R15] ts back in window: resume, continue
// [R16] suspended by ts: in-progress flag stays
// [R17] two-bit termination temperature shift setting
// [R18] start on enable after short check
// [R19] timers advance gated by current ratio
module chgseq_top #(
  parameter int TICK_CYC = `CHGSEQ_TICK_CYC
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        input_power_good,
  input  wire logic        bat_short_ok,
  input  wire logic        bat_above_precharge_exit_voltage,
  input  wire logic        bat_at_regulation,
  input  wire logic        current_below_termination_current_threshold,
  input  wire logic        die_over_regulation,
  input  wire logic        die_over_shutdown,
  input  wire logic        die_cooled,
  input  wire logic        pack_thermistor_input_in_window,
  input  wire logic        pack_thermistor_input_open,
  input  wire logic        load_sharing_active,
  input  wire logic        input_voltage_low,
  input  wire logic [7:0]  current_ratio,
  output logic             charger_on,
  output logic             short_check_source,
  output logic             precharge_select,
  output logic             thermal_reduce,
  output logic             input_path_fet,
  output logic             battery_path_fet,
  output logic             thermistor_bias_on,
  output logic      [1:0]  charge_current_scale,
  output logic      [1:0]  precharge_current_select,
  output logic      [1:0]  termination_temp_shift
);
  localparam int NPIN = 12;

  // ---- pin synchronisers
  logic [NPIN-1:0] pin_raw; // comparator levels
  logic [NPIN-1:0] s1;      // first stage, read only by s2
  logic [NPIN-1:0] s2;
  logic [NPIN-1:0] s3;
  logic [NPIN-1:0] pin;     // accepted levels
  assign pin_raw = {input_voltage_low, load_sharing_active,
                    pack_thermistor_input_open, pack_thermistor_input_in_window,
                    die_cooled, die_over_shutdown, die_over_regulation,
                    current_below_termination_current_threshold,
                    bat_at_regulation, bat_above_precharge_exit_voltage,
                    bat_short_ok, input_power_good};

  // three flops; a level counts once stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1  <= 12'h000;
      s2  <= 12'h000;
      s3  <= 12'h000;
      pin <= 12'h000;
    end else begin
      s1  <= pin_raw;
      s2  <= s1;
      s3  <= s2;
      pin <= (s2 & s3) | (pin & (s2 | s3));
    end
  end

  logic pgood, sc_ok, lowv, vreg, termination_current_threshold, tjreg, tjoff, tjcool;
  logic tswin, tsopen, dpm, vlow;
  assign {vlow, dpm, tsopen, tswin, tjcool, tjoff, tjreg, termination_current_threshold,
          vreg, lowv, sc_ok, pgood} = pin;

  // ---- registers
  logic [31:0] ctrl;       // software control
  logic [31:0] tmr_cfg;    // timer limits in ticks
  logic        fault_flag; // charger_fault_flag
  logic        flag_held;  // in-progress cleared until repower
  logic        die_hot;    // input path shut down
  chgseq_pkg::chgseq_state_t state;
  chgseq_pkg::chgseq_state_t next_state;

  logic term_en;
  logic active;     // a charge phase is running
  logic ts_sense;   // pack sensing enabled
  logic susp;       // suspended by pack temperature
  logic reduced;    // current cut by a regulation loop
  logic progress;   // charging_in_progress_flag
  assign term_en  = ctrl[`CHGSEQ_C_TERM];
  assign active   = state inside {chgseq_pkg::CHGSEQ_PRE, chgseq_pkg::CHGSEQ_FAST,
                                  chgseq_pkg::CHGSEQ_CV};
  assign ts_sense = term_en || !tsopen; // [R5]
  assign susp     = active && ts_sense && !tswin; // [R14]
  assign reduced  = tjreg || dpm || vlow;
  // suspension does not touch the flag, so it stays set
  assign progress = active && !flag_held; // [R16]

  // ---- apb slave, zero wait states
  logic wr_en;
  logic bad_addr;
  assign pready   = 1'b1;
  assign wr_en    = psel && penable && pwrite;
  assign bad_addr = !(paddr inside {`CHGSEQ_A_CTRL, `CHGSEQ_A_TIMER,
                                    `CHGSEQ_A_STATUS});
  assign pslverr  = psel && penable && bad_addr;

  // control and timer limit writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl    <= `CHGSEQ_CTRL_RST;
      tmr_cfg <= `CHGSEQ_TIMER_RST;
    end else if (wr_en) begin
      if (paddr == `CHGSEQ_A_CTRL) ctrl <= {24'h00_0000, pwdata[7:0]};
      if (paddr == `CHGSEQ_A_TIMER) tmr_cfg <= {16'h0000, pwdata[15:0]};
    end
  end

  // read mux; unmapped reads return zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (paddr)
        `CHGSEQ_A_CTRL:  prdata <= ctrl;
        `CHGSEQ_A_TIMER: prdata <= tmr_cfg;
        `CHGSEQ_A_STATUS: begin
          prdata <= 32'h0000_0000;
          prdata[`CHGSEQ_S_ACTIVE] <= progress;
          prdata[`CHGSEQ_S_FAULT]  <= fault_flag;
          prdata[`CHGSEQ_S_SUSP]   <= susp;
          prdata[`CHGSEQ_S_TREG]   <= tjreg;
          prdata[`CHGSEQ_S_HOT]    <= die_hot;
          prdata[`CHGSEQ_S_STATE]  <= state;
        end
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end

  // ---- safety timers
  chgseq_tmr_if pre_t ();
  chgseq_tmr_if fast_t ();
  logic [2:0] weight; // scale 00..11 maps to 1..4 halves of the nominal rate
  assign weight = {1'b0, ctrl[`CHGSEQ_C_SCL]} + 3'h1; // [R6] [R7]
  // precharge current select is deliberately not a term here
  // widen before the product, an 8-bit product would wrap at scales 01 to 11
  assign pre_t.step   = 11'(weight) * 11'(`CHGSEQ_RATIO_FULL); // [R8]
  assign fast_t.step  = 11'(weight) * 11'(current_ratio); // [R9]
  assign pre_t.limit  = tmr_cfg[`CHGSEQ_T_PRE];
  assign fast_t.limit = tmr_cfg[`CHGSEQ_T_FAST];
  // timers only run with termination on, freeze while suspended
  assign pre_t.run  = term_en && state == chgseq_pkg::CHGSEQ_PRE && !susp; // [R4] [R14]
  assign pre_t.clr  = state != chgseq_pkg::CHGSEQ_PRE;
  assign fast_t.run = term_en && !susp && (state == chgseq_pkg::CHGSEQ_FAST
                      || state == chgseq_pkg::CHGSEQ_CV); // [R4] [R15]
  assign fast_t.clr = !(state == chgseq_pkg::CHGSEQ_FAST
                        || state == chgseq_pkg::CHGSEQ_CV);

  chgseq_timer #(.TICK_CYC(TICK_CYC)) u_pre_tmr (
    .pclk    (pclk),
    .presetn (presetn),
    .t       (pre_t.tmr)
  );
  chgseq_timer #(.TICK_CYC(TICK_CYC)) u_fast_tmr (
    .pclk    (pclk),
    .presetn (presetn),
    .t       (fast_t.tmr)
  );

  logic pre_fault;
  logic fast_fault;
  assign pre_fault  = term_en && pre_t.expired && !lowv; // [R10]
  assign fast_fault = term_en && fast_t.expired && !termination_current_threshold; // [R11]

  // ---- charge sequence
  always_comb begin
    next_state = state;
    case (state)
      chgseq_pkg::CHGSEQ_IDLE:
        if (pgood && ctrl[`CHGSEQ_C_EN]) next_state = chgseq_pkg::CHGSEQ_SHORT; // [R18]
      chgseq_pkg::CHGSEQ_SHORT:
        if (sc_ok) next_state = chgseq_pkg::CHGSEQ_PRE; // [R18]
      chgseq_pkg::CHGSEQ_PRE:
        if (lowv) next_state = chgseq_pkg::CHGSEQ_FAST; // [R1]
        else if (pre_fault) next_state = chgseq_pkg::CHGSEQ_FAULT;
      chgseq_pkg::CHGSEQ_FAST:
        if (vreg) next_state = chgseq_pkg::CHGSEQ_CV; // [R1]
        else if (fast_fault) next_state = chgseq_pkg::CHGSEQ_FAULT;
      chgseq_pkg::CHGSEQ_CV: begin
        // without termination cv is left only on power or enable loss and no detection runs
        if (term_en && termination_current_threshold && !reduced && !susp)
          next_state = chgseq_pkg::CHGSEQ_DONE; // [R1] [R2]
        else if (fast_fault) next_state = chgseq_pkg::CHGSEQ_FAULT;
      end
      chgseq_pkg::CHGSEQ_DONE:  next_state = state;
      chgseq_pkg::CHGSEQ_FAULT: next_state = state;
      default: next_state = chgseq_pkg::CHGSEQ_IDLE;
    endcase
    // losing power or enable always restarts
    if (!pgood || !ctrl[`CHGSEQ_C_EN]) next_state = chgseq_pkg::CHGSEQ_IDLE;
  end

  // state register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) state <= chgseq_pkg::CHGSEQ_IDLE;
    else state <= next_state;
  end

  // in-progress hold after taper, released only by repower
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) flag_held <= 1'b0;
    else if (!pgood) flag_held <= 1'b0;
    else if (state == chgseq_pkg::CHGSEQ_CV && !term_en && termination_current_threshold && !reduced
             && !susp) flag_held <= 1'b1; // [R3]
  end

  // fault flag; write one to clear, a new fault wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) fault_flag <= 1'b0;
    else if (next_state == chgseq_pkg::CHGSEQ_FAULT
             && state != chgseq_pkg::CHGSEQ_FAULT) fault_flag <= 1'b1; // [R10] [R11]
    else if (wr_en && paddr == `CHGSEQ_A_STATUS && pwdata[`CHGSEQ_S_FAULT])
      fault_flag <= 1'b0;
  end

  // die shutdown with hysteresis
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) die_hot <= 1'b0;
    else if (tjoff) die_hot <= 1'b1; // [R13]
    else if (tjcool) die_hot <= 1'b0; // [R13]
  end

  // registered analog controls
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      charger_on               <= 1'b0;
      short_check_source       <= 1'b0;
      precharge_select         <= 1'b0;
      thermal_reduce           <= 1'b0;
      input_path_fet           <= 1'b0;
      battery_path_fet         <= 1'b1;
      thermistor_bias_on       <= 1'b0;
      charge_current_scale     <= 2'h0;
      precharge_current_select <= 2'h0;
      termination_temp_shift   <= 2'h0;
    end else begin
      charger_on               <= active && !susp && !die_hot; // [R14] [R15]
      short_check_source       <= state == chgseq_pkg::CHGSEQ_SHORT;
      precharge_select         <= state == chgseq_pkg::CHGSEQ_PRE;
      thermal_reduce           <= tjreg; // [R12]
      input_path_fet           <= pgood && !die_hot; // [R13]
      battery_path_fet         <= die_hot || !pgood || active; // [R13]
      thermistor_bias_on       <= active && ts_sense; // [R5]
      charge_current_scale     <= ctrl[`CHGSEQ_C_SCL];
      precharge_current_select <= ctrl[`CHGSEQ_C_PRE];
      termination_temp_shift   <= ctrl[`CHGSEQ_C_SHIFT]; // [R17]
    end
  end

  // ---- checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  cv_stays_a: assert property (state == chgseq_pkg::CHGSEQ_CV && !term_en && pgood
    && ctrl[`CHGSEQ_C_EN] |=> state == chgseq_pkg::CHGSEQ_CV) // [R1]
    else $error("cv left with termination off");
  no_timer_a: assert property (!term_en |-> !pre_t.run && !fast_t.run) // [R4]
    else $error("timer ran with termination off");
  flag_hold_a: assert property (flag_held && pgood |=> !progress) // [R3]
    else $error("in-progress flag returned without repower");
  susp_flag_a: assert property (active && susp && !flag_held |-> progress) // [R16]
    else $error("in-progress flag dropped while suspended");
  susp_off_a: assert property (susp |=> !charger_on) // [R14]
    else $error("charger stayed on while suspended");
  hot_fet_a: assert property (tjoff |=> die_hot ##1 !input_path_fet && battery_path_fet)
    else $error("shutdown did not swap fets"); // [R13]
  fault_set_a: assert property (state != chgseq_pkg::CHGSEQ_FAULT
    && next_state == chgseq_pkg::CHGSEQ_FAULT |=> fault_flag) // [R11]
    else $error("fault flag not set");
  start_chk_a: assert property (state == chgseq_pkg::CHGSEQ_IDLE
    && next_state != chgseq_pkg::CHGSEQ_IDLE |=> state == chgseq_pkg::CHGSEQ_SHORT)
    else $error("charge began without short check"); // [R18]
  shift_out_a: assert property (##1 termination_temp_shift == $past(ctrl[7:6]))
    else $error("temperature shift not driven"); // [R17]
endmodule : chgseq_top
`default_nettype wire

//--- tb/chgseq_pack_model.sv
// battery pack with thermistor, seen from the charger pins
`timescale 1ns/10ps
`default_nettype none
module chgseq_pack_model #(
  parameter int SC_LVL   = 4,  // short check clears
  parameter int LOWV_LVL = 20, // precharge exit level
  parameter int REG_LVL  = 60, // regulation level
  parameter int TERM_LVL = 90  // taper current below threshold
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        charger_on,
  input  wire logic        thermistor_bias_on,
  input  wire logic        temp_fault,
  input  wire logic        ts_open,
  input  wire logic        fresh,
  input  wire logic [15:0] cap,
  output logic             bat_short_ok,
  output logic             bat_above_precharge_exit_voltage,
  output logic             bat_at_regulation,
  output logic             current_below_termination_current_threshold,
  output logic             pack_thermistor_input_in_window,
  output logic             pack_thermistor_input_open
);
  int   lvl;  // charge level, one step per charging cycle
  logic flip; // unbiased thermistor reads as noise
  // charge only while current is allowed; cap models a stuck cell
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl  <= 0;
      flip <= 1'b0;
    end else begin
      flip <= ~flip;
      if (fresh) begin
        // a healthy fresh pack already sits at the short threshold
        lvl <= SC_LVL;
      end else if (charger_on && lvl < int'(cap)) begin
        lvl <= lvl + 1;
      end
    end
  end
  assign bat_short_ok = lvl >= SC_LVL;
  assign bat_above_precharge_exit_voltage = lvl >= LOWV_LVL;
  assign bat_at_regulation = lvl >= REG_LVL;
  assign current_below_termination_current_threshold = lvl >= TERM_LVL;
  // no bias current means no valid reading, so it toggles
  assign pack_thermistor_input_in_window = thermistor_bias_on ? !(temp_fault || ts_open) : flip;
  assign pack_thermistor_input_open = ts_open;
endmodule : chgseq_pack_model
`default_nettype wire

//--- tb/charger_control_sequencer_tb.sv
// self-checking bench for the charger control sequencer
`timescale 1ns/10ps
`default_nettype none
`include "chgseq_defs.svh"
module charger_control_sequencer_tb;
  localparam int TICK = 4; // short tick keeps timer runs brief
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, rd;
  logic input_power_good = 1'b1, die_over_regulation = 1'b0, die_over_shutdown = 1'b0;
  logic die_cooled = 1'b1, load_sharing_active = 1'b0, input_voltage_low = 1'b0;
  logic temp_fault = 1'b0, ts_open = 1'b0, fresh = 1'b0, err;
  logic [7:0] current_ratio = 8'hff;
  logic [15:0] cap = 16'h0000;
  logic [31:0] prdata;
  logic pready, pslverr, charger_on, short_check_source, precharge_select, thermal_reduce;
  logic input_path_fet, battery_path_fet, thermistor_bias_on, bat_short_ok, bat_at_regulation;
  logic bat_above_precharge_exit_voltage, current_below_termination_current_threshold;
  logic pack_thermistor_input_in_window, pack_thermistor_input_open;
  logic [1:0] charge_current_scale, precharge_current_select, termination_temp_shift;
  int cyc = 0, pre_cyc = 0, on_cyc = 0, n_fail = 0, n_compared = 0, p, r;
  chgseq_top #(.TICK_CYC(TICK)) chgseq_top_i (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .input_power_good, .bat_short_ok,
    .bat_above_precharge_exit_voltage, .bat_at_regulation, .die_over_regulation,
    .current_below_termination_current_threshold, .die_over_shutdown, .die_cooled,
    .pack_thermistor_input_in_window, .pack_thermistor_input_open, .load_sharing_active,
    .input_voltage_low, .current_ratio, .charger_on, .short_check_source, .precharge_select,
    .thermal_reduce, .input_path_fet, .battery_path_fet, .thermistor_bias_on,
    .charge_current_scale, .precharge_current_select, .termination_temp_shift);
  chgseq_pack_model chgseq_pack_model_i (.pclk, .presetn, .charger_on, .thermistor_bias_on,
    .temp_fault, .ts_open, .fresh, .cap, .bat_short_ok, .bat_above_precharge_exit_voltage,
    .bat_at_regulation, .current_below_termination_current_threshold,
    .pack_thermistor_input_in_window, .pack_thermistor_input_open);
  always #2 pclk = ~pclk; // 250 MHz
  // phase time counters and hang guard
  always @(posedge pclk) begin
    cyc++;
    if (precharge_select === 1'b1) pre_cyc++;
    if (charger_on === 1'b1) on_cyc++;
    if (cyc == 40000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_compared++;
    if (s !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  // timer model: limit ticks, weight scale+1 against nominal 2, ratio slows
  task automatic chk_time(input string nm, input int e, input int s);
    n_compared++;
    if (s < e - e / 8 - 12 || s > e + e / 8 + 12) begin
      n_fail++;
      $display("ERROR %s expected %0d seen %0d", nm, e, s);
    end
  endtask : chk_time
  // one apb transfer, held until pready at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wait_state(input chgseq_pkg::chgseq_state_t st);
    int k = 0;
    do begin
      apb(1'b0, `CHGSEQ_A_STATUS, 32'h0000_0000);
      k++;
    end while (rd[`CHGSEQ_S_STATE] !== st && k < 3000);
    chk("state", 32'(st), 32'(rd[`CHGSEQ_S_STATE]));
  endtask : wait_state
  // stop, clear fault, fresh pack, then start with new control
  task automatic start(input logic [31:0] c, input int lv);
    apb(1'b1, `CHGSEQ_A_CTRL, 32'h0000_0000);
    apb(1'b1, `CHGSEQ_A_STATUS, 32'h0000_0002);
    fresh <= 1'b1;
    cap <= lv[15:0];
    @(posedge pclk);
    fresh <= 1'b0;
    pre_cyc = 0;
    on_cyc = 0;
    apb(1'b1, `CHGSEQ_A_CTRL, c);
  endtask : start
  initial begin
    void'($urandom(34));
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `CHGSEQ_A_CTRL, 32'h0000_0000);
    chk("ctrl reset", `CHGSEQ_CTRL_RST, rd);
    apb(1'b0, `CHGSEQ_A_TIMER, 32'h0000_0000);
    chk("timer reset", `CHGSEQ_TIMER_RST, rd);
    apb(1'b0, `CHGSEQ_A_STATUS, 32'h0000_0000);
    chk("status reset", 32'h0000_0020, rd);
    apb(1'b0, 12'h00c, 32'h0000_0000);
    chk("unmapped error", 32'h0000_0001, {31'h0, err});
    apb(1'b1, `CHGSEQ_A_TIMER, 32'h0000_2006);
    // precharge timeout at every scale, random precharge current
    for (int s = 0; s < 4; s++) begin
      p = $urandom_range(3, 0);
      start({24'h0, s[1:0], p[1:0], s[1:0], 2'b11}, 10);
      wait_state(chgseq_pkg::CHGSEQ_FAULT);
      chk_time("precharge time", 6 * TICK * 2 / (s + 1), pre_cyc);
      chk("fault flag", 32'h0000_0002, rd & 32'h0000_0002);
      chk("shift copy", 32'(s), 32'(termination_temp_shift));
      chk("precharge copy", 32'(p), 32'(precharge_current_select));
    end
    // fast timeout with a suspension: no cut, then load sharing, then low input voltage
    for (int i = 0; i < 3; i++) begin
      r = (i > 0) ? $urandom_range(255, 100) : 255;
      current_ratio <= r[7:0];
      load_sharing_active <= (i == 1);
      input_voltage_low <= (i == 2);
      start(32'h0000_0007, 40);
      wait_state(chgseq_pkg::CHGSEQ_FAST);
      temp_fault <= 1'b1;
      repeat (10) @(posedge pclk);
      apb(1'b0, `CHGSEQ_A_STATUS, 32'h0000_0000);
      chk("suspended active", 32'h0000_0005, rd & 32'h0000_0005);
      temp_fault <= 1'b0;
      wait_state(chgseq_pkg::CHGSEQ_FAULT);
      chk_time("fast time", 32 * TICK * 255 / r, on_cyc - pre_cyc);
    end
    current_ratio <= 8'hff;
    load_sharing_active <= 1'b0;
    input_voltage_low <= 1'b0;
    // termination off with open thermistor and tiny limits
    ts_open <= 1'b1;
    apb(1'b1, `CHGSEQ_A_TIMER, 32'h0000_0101);
    start(32'h0000_0005, 200);
    wait_state(chgseq_pkg::CHGSEQ_CV);
    repeat (300) @(posedge pclk);
    apb(1'b0, `CHGSEQ_A_STATUS, 32'h0000_0000);
    chk("term off status", 32'h0000_0200, rd & 32'h0000_0fe3);
    chk("ts bias", 32'h0000_0000, {31'h0, thermistor_bias_on});
    // die regulation, shutdown and hysteresis
    die_over_regulation <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("reduce", 32'h0000_0001, {31'h0, thermal_reduce});
    die_over_shutdown <= 1'b1;
    die_cooled <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("fets hot", 32'h0000_0001, {30'h0, input_path_fet, battery_path_fet});
    die_over_shutdown <= 1'b0;
    repeat (8) @(posedge pclk);
    chk("fets cooling", 32'h0000_0001, {30'h0, input_path_fet, battery_path_fet});
    die_cooled <= 1'b1;
    repeat (8) @(posedge pclk);
    chk("fet back", 32'h0000_0001, {31'h0, input_path_fet});
    die_over_regulation <= 1'b0;
    // full charge with termination on
    ts_open <= 1'b0;
    apb(1'b1, `CHGSEQ_A_TIMER, 32'h0000_ffff);
    start(32'h0000_0007, 200);
    wait_state(chgseq_pkg::CHGSEQ_DONE);
    complete_run();
  end
endmodule : charger_control_sequencer_tb
`default_nettype wire
